// [rtl/tpc_consts.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef TPC_CONSTS_SVH
`define TPC_CONSTS_SVH
`define TPC_OFF_PROC3_CFG 8'h06
`define TPC_OFF_IRQ_EN 8'h07
`define TPC_OFF_STATUS 8'h08
`define TPC_OFF_LOM_FLAG 8'h09
`define TPC_OFF_GROUP_BASE 8'h60
`define TPC_OFF_TU_STAT 8'h60
`define TPC_OFF_TU_LOP 8'h67
`define TPC_BIT_ENABLE 7
`define TPC_BIT_SPACING 6
`define TPC_BIT_MON_SRC 5
`define TPC_BIT_IDLE_SEL 4
`define TPC_BIT_FILT_BYP 3
`define TPC_BIT_TU3 2
`define TPC_BIT_IN_TUG3 1
`define TPC_BIT_OUT_TUG3 0
`define TPC_CFG_RESET 8'h00
`define TPC_IRQ_EN_RESET 8'h00
`define TPC_FILT_COUNT 2'h3
`define TPC_SPACING_FRAMES 2'h3
`endif

// [rtl/tpc_pkg.sv]
// Types shared by the tributary processor configuration block
package tpc_pkg;
   typedef enum logic [1:0] {
      TPC_AXI_IDLE = 2'b00,
      TPC_AXI_RESP = 2'b01
   } tpc_axi_state_t;
endpackage

// [rtl/tpc_pointer_track.sv]
// Pointer filter and justification spacing tracker for one processor
`timescale 1ns/100ps
`include "tpc_consts.svh"
module tpc_pointer_track
   import tpc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run,
   input wire logic filt_bypass,
   input wire logic spacing_enforce,
   input wire logic frame_strobe,
   input wire logic [9:0] ptr_value,
   input wire logic ptr_is_just,
   input wire logic ptr_new_data,
   output logic [9:0] active_ptr,
   output logic just_event
);
   logic [9:0] candidate;
   logic [1:0] match_count;
   logic [1:0] since_change;
   wire logic is_change = ptr_value != active_ptr;
   wire logic spacing_ok = !spacing_enforce || since_change >= `TPC_SPACING_FRAMES;
   wire logic just_ok = ptr_is_just && spacing_ok;
   wire logic repeat_hit = ptr_value == candidate && match_count == `TPC_FILT_COUNT - 2'h1;
   wire logic take = filt_bypass || ptr_new_data || just_ok || repeat_hit;
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         active_ptr <= 10'h000;
         candidate <= 10'h000;
         match_count <= 2'h0;
         since_change <= 2'h0;
         just_event <= 1'b0;
      end else begin
         just_event <= 1'b0;
         if (frame_strobe) begin
            if (is_change && take) begin
               active_ptr <= ptr_value;
               since_change <= 2'h0;
               match_count <= 2'h0;
               just_event <= ptr_is_just;
            end else begin
               if (since_change != 2'h3)
                  since_change <= since_change + 2'h1;
               if (is_change && ptr_value == candidate) begin
                  match_count <= match_count + 2'h1;
               end else begin
                  candidate <= ptr_value;
                  match_count <= {1'b0, is_change};
               end
            end
         end
      end
   end
endmodule // tpc_pointer_track

// [rtl/tpc_config_regs.sv]
// Processor three configuration and interrupt enable registers over AXI4-Lite
//
// Overview of operation
// - Filter illegal pointer changes until three repeats
// - Bypass field applies pointer changes at once
// - Idle pattern zeros or ones by select
// - Idle overwrites payload only, pointer unaffected
// - Monitor source picks incoming or outgoing stream
// - Justification event may raise enabled interrupt
// - Spacing enforce requires three frames since change
// - Enable low holds sub-blocks reset, passes data
// - Bypass delay follows J1 marker spacing
// - Enable falling resets group registers at 0x60+
// - Outgoing mapping picks TUG3 or VC3 handling
// - Incoming mapping picks TUG3 or VC3 handling
// - Single TU3 mode overrides both mapping fields
// - TU3 mode: only 60H, 67H live
// - Otherwise 60H TU1 status, 67H LOP summary
// - Top enable gates output, pending still visible
// - Framer enable unmasks multiframe change interrupt
// - AU4 takes multiframe from processor one
// - Pending clears when processor status read
// - Framer flag sets both edges, clears on read
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/100ps
`include "tpc_consts.svh"
module tpc_config_regs
   import tpc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic frame_strobe,
   input wire logic [9:0] in_ptr_value,
   input wire logic in_ptr_is_just,
   input wire logic in_ptr_new_data,
   input wire logic out_just_pulse,
   input wire logic [2:0] proc_source_pending,
   input wire logic [2:0] proc_source_enabled,
   input wire logic [2:0] proc_status_read,
   input wire logic [2:0] lom_state,
   input wire logic au4_mode,
   input wire logic [7:0] in_data,
   input wire logic idle_insert,
   input wire logic payload_byte,
   input wire logic [7:0] bypass_delayed_data,
   input wire logic [7:0] proc_data,
   output logic [7:0] out_data,
   output logic [9:0] active_ptr,
   output logic subblock_reset,
   output logic group_regs_clear,
   output logic tu3_mode,
   output logic in_tug3_mode,
   output logic out_tug3_mode,
   output logic [2:0] lom_select,
   output logic [2:0] pending,
   output logic interrupt_out_n
);
   // ==========================================================
   // Synchronisers for pin-level inputs
   logic [2:0] lom_meta;
   logic [2:0] lom_sync;
   logic [2:0] lom_prev;
   always_ff @(posedge aclk) begin
      lom_meta <= lom_state;
      lom_sync <= lom_meta;
      lom_prev <= lom_sync;
   end

   // ==========================================================
   // Registers
   logic [7:0] payload_proc3_config;
   logic [7:0] payload_proc_lom_irq_enable;
   logic [2:0] multiframe_change_flag;
   logic just_flag;
   logic prev_enable;
   logic [31:0] next_rdata;
   wire logic processing_enable = payload_proc3_config[`TPC_BIT_ENABLE];
   wire logic justification_spacing_enforce = payload_proc3_config[`TPC_BIT_SPACING];
   wire logic justification_monitor_source = payload_proc3_config[`TPC_BIT_MON_SRC];
   wire logic idle_pattern_select = payload_proc3_config[`TPC_BIT_IDLE_SEL];
   wire logic pointer_filter_bypass = payload_proc3_config[`TPC_BIT_FILT_BYP];
   wire logic single_tu3 = payload_proc3_config[`TPC_BIT_TU3];
   wire logic incoming_tug3_mapping = payload_proc3_config[`TPC_BIT_IN_TUG3];
   wire logic outgoing_tug3_mapping = payload_proc3_config[`TPC_BIT_OUT_TUG3];
   wire logic [2:0] payload_proc_irq_enable = payload_proc_lom_irq_enable[2:0];
   wire logic [2:0] multiframe_irq_enable = payload_proc_lom_irq_enable[5:3];

   // ==========================================================
   // Register address decode, word index to byte address
   function automatic logic [7:0] byte_addr(input logic [7:0] index);
      return {index[5:0], 2'b00};
   endfunction
   function automatic logic known_addr(input logic [7:0] addr);
      return addr == byte_addr(`TPC_OFF_PROC3_CFG) || addr == byte_addr(`TPC_OFF_IRQ_EN)
         || addr == byte_addr(`TPC_OFF_STATUS) || addr == byte_addr(`TPC_OFF_LOM_FLAG);
   endfunction
   wire logic [7:0] cfg_addr = byte_addr(`TPC_OFF_PROC3_CFG);
   wire logic [7:0] irq_addr = byte_addr(`TPC_OFF_IRQ_EN);
   wire logic [7:0] status_addr = byte_addr(`TPC_OFF_STATUS);
   wire logic [7:0] flag_addr = byte_addr(`TPC_OFF_LOM_FLAG);

   // ==========================================================
   // AXI4-Lite write path
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [7:0] w_data;
   logic w_lane0;
   wire logic aw_fire = s_axi_awvalid && s_axi_awready;
   wire logic w_fire = s_axi_wvalid && s_axi_wready;
   wire logic do_write = aw_held && w_held && !s_axi_bvalid;
   wire logic b_done = s_axi_bvalid && s_axi_bready;
   wire logic wr_cfg = do_write && w_lane0 && aw_addr == cfg_addr;
   wire logic wr_irq = do_write && w_lane0 && aw_addr == irq_addr;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !aw_fire;
         if (aw_fire) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'b00};
         end else if (b_done) begin
            aw_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 8'h00;
         w_lane0 <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_held && !w_fire;
         if (w_fire) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end else if (b_done) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= known_addr(aw_addr) ? 2'b00 : 2'b10;
      end else if (b_done) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // AXI4-Lite read path
   tpc_axi_state_t rd_state;
   wire logic ar_fire = s_axi_arvalid && s_axi_arready;
   wire logic [7:0] ar_addr = {s_axi_araddr[7:2], 2'b00};
   wire logic rd_flags = ar_fire && ar_addr == flag_addr;
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (ar_addr)
         cfg_addr: next_rdata[7:0] = payload_proc3_config;
         irq_addr: next_rdata[7:0] = {2'b00, payload_proc_lom_irq_enable[5:0]};
         status_addr: next_rdata[7:0] = {2'b00, lom_sync, pending};
         flag_addr: next_rdata[7:0] = {2'b00, multiframe_change_flag, 3'b000};
         default: next_rdata = 32'h0000_0000;
      endcase
   end
   wire logic rd_known = known_addr(ar_addr);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state <= TPC_AXI_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else begin
         case (rd_state)
            TPC_AXI_IDLE: begin
               s_axi_arready <= !ar_fire;
               if (ar_fire) begin
                  s_axi_rvalid <= 1'b1;
                  s_axi_rdata <= next_rdata;
                  s_axi_rresp <= rd_known ? 2'b00 : 2'b10;
                  rd_state <= TPC_AXI_RESP;
               end
            end
            TPC_AXI_RESP: begin
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  s_axi_arready <= 1'b1;
                  rd_state <= TPC_AXI_IDLE;
               end
            end
            default: rd_state <= TPC_AXI_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Configuration and enable registers
   always_ff @(posedge aclk) begin
      if (!aresetn)
         payload_proc3_config <= `TPC_CFG_RESET;
      else if (wr_cfg)
         payload_proc3_config <= w_data;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         payload_proc_lom_irq_enable <= `TPC_IRQ_EN_RESET;
      else if (wr_irq)
         payload_proc_lom_irq_enable <= {2'b00, w_data[5:0]};
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         prev_enable <= 1'b0;
      else
         prev_enable <= processing_enable;
   end

   // ==========================================================
   // Pointer tracking
   wire logic monitored_just;
   tpc_pointer_track u_track (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(processing_enable),
      .filt_bypass(pointer_filter_bypass),
      .spacing_enforce(justification_spacing_enforce),
      .frame_strobe(frame_strobe),
      .ptr_value(in_ptr_value),
      .ptr_is_just(in_ptr_is_just),
      .ptr_new_data(in_ptr_new_data),
      .active_ptr(active_ptr),
      .just_event(monitored_just)
   );
   wire logic just_src = justification_monitor_source ? monitored_just : out_just_pulse;

   // ==========================================================
   // Flags and interrupt
   wire logic [2:0] lom_change = lom_sync ^ lom_prev;
   wire logic [2:0] next_pending = (pending & ~proc_status_read)
      | (proc_source_pending & proc_source_enabled);
   wire logic [2:0] next_lom_flag = (multiframe_change_flag & {3{!rd_flags}})
      | lom_change;
   wire logic next_just = just_flag & !rd_flags | (just_src && processing_enable);
   wire logic any_irq = |(pending & payload_proc_irq_enable)
      || |(multiframe_change_flag & multiframe_irq_enable)
      || (just_flag && payload_proc_irq_enable[2]);
   always_ff @(posedge aclk) begin
      if (!aresetn)
         pending <= 3'b000;
      else
         pending <= next_pending;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         multiframe_change_flag <= 3'b000;
         just_flag <= 1'b0;
      end else begin
         multiframe_change_flag <= next_lom_flag;
         just_flag <= next_just;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         interrupt_out_n <= 1'b1;
      else
         interrupt_out_n <= !any_irq;
   end

   // ==========================================================
   // Mode outputs and data path
   wire logic [7:0] idle_byte = idle_pattern_select ? 8'hff : 8'h00;
   wire logic [7:0] proc_byte = (idle_insert && payload_byte) ? idle_byte : proc_data;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         subblock_reset <= 1'b1;
         group_regs_clear <= 1'b0;
      end else begin
         subblock_reset <= !processing_enable;
         group_regs_clear <= prev_enable && !processing_enable;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tu3_mode <= 1'b0;
         in_tug3_mode <= 1'b0;
         out_tug3_mode <= 1'b0;
      end else begin
         tu3_mode <= single_tu3;
         in_tug3_mode <= single_tu3 || incoming_tug3_mapping;
         out_tug3_mode <= single_tu3 || outgoing_tug3_mapping;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         lom_select <= 3'b000;
      else
         lom_select <= au4_mode ? 3'b001 : 3'b100;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         out_data <= 8'h00;
      else
         out_data <= processing_enable ? proc_byte : bypass_delayed_data;
   end
   wire logic unused_in = |in_data;
endmodule // tpc_config_regs

// [verif/tpc_config_regs_props.sv]
// Concurrent checks on the processor three configuration block ports
`timescale 1ns/100ps
module tpc_config_regs_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] bypass_delayed_data,
   input wire logic [7:0] out_data,
   input wire logic subblock_reset,
   input wire logic group_regs_clear,
   input wire logic tu3_mode,
   input wire logic in_tug3_mode,
   input wire logic out_tug3_mode,
   input wire logic au4_mode,
   input wire logic [2:0] lom_select,
   input wire logic [2:0] pending,
   input wire logic [2:0] proc_source_pending,
   input wire logic [2:0] proc_source_enabled,
   input wire logic [2:0] proc_status_read
);
   // ==========================================
   // Sequences
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence clear_pulse;
      subblock_reset && group_regs_clear ##1 !group_regs_clear;
   endsequence
   // ==========================================
   // Assertions
   read_answer_a: assert property (ar_taken |=> s_axi_rvalid)
      else $error("read answer not one cycle after address");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read answer dropped early");
   write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped early");
   group_clear_a: assert property (group_regs_clear |-> clear_pulse)
      else $error("group clear not a pulse while disabled");
   bypass_data_a: assert property ($past(aresetn) && subblock_reset && $past(subblock_reset)
      |-> out_data == $past(bypass_delayed_data)) else $error("bypass data altered");
   tu3_override_a: assert property (tu3_mode |-> in_tug3_mode && out_tug3_mode)
      else $error("single TU3 does not override mapping");
   au4_select_a: assert property ($past(aresetn)
      |-> lom_select == ($past(au4_mode) ? 3'b001 : 3'b100)) else $error("framer select wrong");
   pending_set_a: assert property ($past(aresetn) |-> (pending & ~$past(pending)
      & ~$past(proc_source_pending & proc_source_enabled)) == 3'b000)
      else $error("pending set without enabled source");
   pending_clear_a: assert property ($past(aresetn) |-> (~pending & $past(pending)
      & ~$past(proc_status_read)) == 3'b000) else $error("pending cleared without read");
endmodule // tpc_config_regs_props

bind tpc_config_regs tpc_config_regs_props u_props (.*);

// [verif/tb_tributary_proc_config_irq_enable.sv]
// Register-level testbench for the processor three configuration block
`timescale 1ns/100ps
`include "tpc_consts.svh"
module tb_tributary_proc_config_irq_enable;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic frame_strobe, in_ptr_is_just, in_ptr_new_data, out_just_pulse, au4_mode;
   logic idle_insert, payload_byte, subblock_reset, group_regs_clear, tu3_mode;
   logic in_tug3_mode, out_tug3_mode, interrupt_out_n;
   logic [7:0] s_axi_awaddr, s_axi_araddr, in_data, bypass_delayed_data, proc_data, out_data;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [9:0] in_ptr_value, active_ptr;
   logic [2:0] proc_source_pending, proc_source_enabled, proc_status_read, lom_state;
   logic [2:0] lom_select, pending;
   int errors, n_checks;
   localparam logic [7:0] cfg_a = 8'(`TPC_OFF_PROC3_CFG * 4);
   localparam logic [7:0] irq_a = 8'(`TPC_OFF_IRQ_EN * 4);
   localparam logic [7:0] st_a = 8'(`TPC_OFF_STATUS * 4);
   localparam logic [7:0] lom_a = 8'(`TPC_OFF_LOM_FLAG * 4);
   logic [7:0] mtab [4] = '{8'h04, 8'h07, 8'h01, 8'h02};
   logic [2:0] mexp [4] = '{3'b111, 3'b111, 3'b001, 3'b010};

   tpc_config_regs dut (.*);

   always #5 aclk = ~aclk;
   // ==========================================
   // Tasks
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      fork
         begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 0; end
         begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 0; end
      join
      do @(posedge aclk); while (!s_axi_bvalid);
      rr = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge aclk); while (!s_axi_rvalid);
      rv = s_axi_rdata; rr = s_axi_rresp;
      s_axi_rready <= 0;
      chk({rr, rv}, {er, e});
   endtask
   task automatic frame(input logic [9:0] v);
      @(posedge aclk);
      frame_strobe <= 1; in_ptr_value <= v;
      @(posedge aclk);
      frame_strobe <= 0;
      cyc(3);
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========================================
   // Watchdog
   initial begin
      repeat (5000) @(posedge aclk);
      errors++;
      test_done();
   end
   // ==========================================
   // Tests
   initial begin
      aclk = 0; aresetn = 0; s_axi_wstrb = 4'hf; in_data = 8'h00;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {frame_strobe, in_ptr_is_just, in_ptr_new_data, out_just_pulse, au4_mode} = '0;
      {idle_insert, payload_byte, proc_source_pending, proc_source_enabled} = '0;
      {proc_status_read, lom_state, in_ptr_value} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, bypass_delayed_data, proc_data} = '0;
      cyc(2);
      aresetn <= 1;
      chk(subblock_reset, 1);
      chk(interrupt_out_n, 1);
      rchk(cfg_a, 32'h0, 2'b00);
      rchk(irq_a, 32'h0, 2'b00);
      rchk(st_a, 32'h0, 2'b00);
      rchk(8'h30, 32'h0, 2'b10);
      wr(8'h30, 32'h1);
      chk(rr, 2'b10);
      foreach (mtab[i]) begin
         wr(cfg_a, {24'h0, mtab[i]});
         cyc(2);
         chk({tu3_mode, in_tug3_mode, out_tug3_mode}, mexp[i]);
      end
      wr(cfg_a, 32'h80);
      proc_data <= 8'h5a; idle_insert <= 1; payload_byte <= 1; bypass_delayed_data <= 8'hc3;
      cyc(3);
      chk(subblock_reset, 0);
      chk(out_data, 8'h00);
      payload_byte <= 0;
      cyc(2);
      chk(out_data, 8'h5a);
      wr(cfg_a, 32'h90);
      payload_byte <= 1;
      cyc(2);
      chk(out_data, 8'hff);
      rchk(cfg_a, 32'h90, 2'b00);
      repeat (2) frame(10'd100);
      chk(active_ptr, 10'd0);
      frame(10'd100);
      chk(active_ptr, 10'd100);
      wr(cfg_a, 32'h98);
      frame(10'd200);
      chk(active_ptr, 10'd200);
      wr(cfg_a, 32'h0);
      cyc(3);
      chk(subblock_reset, 1);
      chk(out_data, 8'hc3);
      proc_source_pending <= 3'b110; proc_source_enabled <= 3'b100;
      cyc(3);
      rchk(st_a, 32'h4, 2'b00);
      chk(interrupt_out_n, 1);
      wr(irq_a, 32'h06);
      cyc(2);
      chk(interrupt_out_n, 0);
      proc_source_pending <= 3'b000;
      cyc(3);
      chk(pending, 3'b100);
      proc_status_read <= 3'b100;
      cyc(1);
      proc_status_read <= 3'b000;
      cyc(2);
      chk(pending, 3'b000);
      chk(interrupt_out_n, 1);
      wr(irq_a, 32'h20);
      lom_state <= 3'b100;
      cyc(6);
      chk(interrupt_out_n, 0);
      rchk(st_a, 32'h20, 2'b00);
      rchk(lom_a, 32'h20, 2'b00);
      cyc(2);
      chk(interrupt_out_n, 1);
      rchk(lom_a, 32'h0, 2'b00);
      wr(irq_a, 32'h0);
      lom_state <= 3'b000;
      cyc(6);
      chk(interrupt_out_n, 1);
      rchk(lom_a, 32'h20, 2'b00);
      au4_mode <= 1;
      cyc(2);
      chk(lom_select, 3'b001);
      au4_mode <= 0;
      cyc(2);
      chk(lom_select, 3'b100);
      wr(irq_a, 32'h04);
      wr(cfg_a, 32'he0);
      in_ptr_is_just <= 1; out_just_pulse <= 1;
      cyc(1);
      out_just_pulse <= 0;
      for (int v = 1; v < 4; v++) frame(10'(v));
      chk(active_ptr, 10'd0);
      chk(interrupt_out_n, 1);
      frame(10'd4);
      chk(active_ptr, 10'd4);
      chk(interrupt_out_n, 0);
      in_ptr_is_just <= 0;
      wr(cfg_a, 32'hc0);
      rchk(lom_a, 32'h0, 2'b00);
      cyc(2);
      chk(interrupt_out_n, 1);
      out_just_pulse <= 1;
      cyc(1);
      out_just_pulse <= 0;
      cyc(3);
      chk(interrupt_out_n, 0);
      test_done();
   end
endmodule // tb_tributary_proc_config_irq_enable
